/* File: hdl/slr_pkg.sv */
// Package: register map, field layout, reset values and carriers
package slr_pkg;

	// Printed offsets are register indices; byte address is index times four
	localparam logic [11:0] SLR_IDX_LINK_EN = 12'h200;
	localparam logic [11:0] SLR_IDX_MODE = 12'h201;
	localparam logic [11:0] SLR_IDX_KM1 = 12'h202;
	localparam logic [11:0] SLR_IDX_SYNC = 12'h203;
	localparam logic [11:0] SLR_IDX_CTRL = 12'h204;
	localparam logic [11:0] SLR_IDX_STAT = 12'h20f;
	localparam int SLR_ADDR_W = 14;
	localparam int SLR_REG_W = 8;

	localparam logic [7:0] SLR_RST_LINK_EN = 8'h01;
	localparam logic [7:0] SLR_RST_MODE = 8'h02;
	localparam logic [7:0] SLR_RST_KM1 = 8'h1f;
	localparam logic [7:0] SLR_RST_SYNC = 8'h01;
	localparam logic [7:0] SLR_RST_CTRL = 8'h02;

	localparam int SLR_EN_BIT = 0;
	localparam int SLR_SYNCN_BIT = 0;
	localparam int SLR_SCR_BIT = 0;
	localparam int SLR_FMT_BIT = 1;
	localparam int SLR_SEL_LO = 2;
	localparam int SLR_SEL_HI = 3;
	localparam int SLR_FLD5_HI = 4;

	localparam logic [1:0] SLR_SEL_SE_PIN = 2'h0;
	localparam logic [1:0] SLR_SEL_DIFF = 2'h1;
	localparam logic [1:0] SLR_SEL_NONE = 2'h2;

	// Link configuration as applied to the link logic
	typedef struct packed {
		logic [4:0] output_mode_select;
		logic [4:0] frames_per_multiframe_minus_one;
		logic sample_format_select;
		logic scrambler_enable;
	} slr_cfg_s;

	// Link control outputs
	typedef struct packed {
		logic link_rst_n;
		logic serializer_pd;
		logic link_clk_en;
		logic lmfc_rst_n;
		logic sync_request;
	} slr_ctl_s;

endpackage : slr_pkg

/* File: hdl/slr_sync3.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module slr_sync3
	import slr_pkg::*;
#(
	parameter logic RST_VAL = 1'b1
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic din,
	output logic dout
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Change counts once second and third stage agree
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			dout <= RST_VAL;
		end else if (s2_q == s3_q) begin
			dout <= s3_q;
		end
	end
endmodule : slr_sync3

/* File: hdl/slr_lmfc.sv */
// Local multiframe counter, realigned by the frame sync pulse
`timescale 1ns/1ps
module slr_lmfc
	import slr_pkg::*;
#(
	parameter int K_W = 5
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic run,
	input wire logic align,
	input wire logic [K_W-1:0] km1,
	output logic [K_W-1:0] count,
	output logic boundary
);
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			count <= '0;
			boundary <= 1'b0;
		end else if (!run) begin
			count <= '0;
			boundary <= 1'b0;
		end else if (align || count == km1) begin
			count <= '0;
			boundary <= 1'b1;
		end else begin
			count <= count + K_W'(1);
			boundary <= 1'b0;
		end
	end
endmodule : slr_lmfc

/* File: hdl/slr_regs.sv */
// Serial link control register bank with APB slave
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module slr_regs
	import slr_pkg::*;
#(
	parameter int K_W = 5
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [SLR_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic single_ended_sync_pin_n,
	input wire logic timestamp_diff_input_n,
	input wire logic sysref,
	input wire logic calibration_enable,
	output slr_cfg_s link_cfg,
	output slr_ctl_s link_ctl,
	output logic [K_W-1:0] lmfc_count,
	output logic lmfc_boundary
);
	// Field width is fixed by the register layout
	if (K_W != 5) begin : g_bad_k_w
		$error("K_W must be 5 to match the register field");
	end

	////////////////////////////////////////////////////////////////////////
	// Register storage
	logic [7:0] en_q;
	logic [7:0] mode_q;
	logic [7:0] km1_q;
	logic [7:0] syncn_q;
	logic [7:0] ctrl_q;
	logic link_on;
	logic se_sync_n;
	logic diff_sync_n;
	logic sync_req_d;
	logic sysref_s;
	logic sysref_prev_q;
	logic sysref_rise;
	logic [K_W-1:0] cnt_w;
	logic bnd_w;
	logic [7:0] rd_word;
	logic [4:0] mode_cfg_q;
	logic [4:0] km1_cfg_q;
	logic fmt_cfg_q;
	logic scr_cfg_q;
	logic link_rst_n_q;
	logic serializer_pd_q;
	logic link_clk_en_q;
	logic lmfc_rst_n_q;
	logic sync_request_q;

	// Decode of byte address to register index
	function automatic logic hit(input logic [SLR_ADDR_W-1:0] a,
			input logic [11:0] idx);
		return (a[1:0] == 2'h0) && (a[SLR_ADDR_W-1:2] == idx);
	endfunction : hit

	function automatic logic mapped(input logic [SLR_ADDR_W-1:0] a);
		return hit(a, SLR_IDX_LINK_EN) || hit(a, SLR_IDX_MODE) ||
			hit(a, SLR_IDX_KM1) || hit(a, SLR_IDX_SYNC) ||
			hit(a, SLR_IDX_CTRL) || hit(a, SLR_IDX_STAT);
	endfunction : mapped

	logic wr_acc;
	logic rd_acc;
	assign wr_acc = psel && penable && pwrite && pstrb[0];
	assign rd_acc = psel && !penable && !pwrite;

	assign link_on = en_q[SLR_EN_BIT];

	////////////////////////////////////////////////////////////////////////
	// Register writes; reserved bits kept as written
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			en_q <= SLR_RST_LINK_EN;
		end else if (wr_acc && hit(paddr, SLR_IDX_LINK_EN)) begin
			en_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			mode_q <= SLR_RST_MODE;
		end else if (wr_acc && hit(paddr, SLR_IDX_MODE)) begin
			mode_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			km1_q <= SLR_RST_KM1;
		end else if (wr_acc && hit(paddr, SLR_IDX_KM1)) begin
			km1_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			syncn_q <= SLR_RST_SYNC;
		end else if (wr_acc && hit(paddr, SLR_IDX_SYNC)) begin
			syncn_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= SLR_RST_CTRL;
		end else if (wr_acc && hit(paddr, SLR_IDX_CTRL)) begin
			ctrl_q <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB answer: no wait state, read data captured in setup
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && !penable && !mapped(paddr);
		end
	end

	always_comb begin
		rd_word = 8'h00;
		if (hit(paddr, SLR_IDX_LINK_EN)) begin
			rd_word = en_q;
		end
		if (hit(paddr, SLR_IDX_MODE)) begin
			rd_word = mode_q;
		end
		if (hit(paddr, SLR_IDX_KM1)) begin
			rd_word = km1_q;
		end
		if (hit(paddr, SLR_IDX_SYNC)) begin
			rd_word = syncn_q;
		end
		if (hit(paddr, SLR_IDX_CTRL)) begin
			rd_word = ctrl_q;
		end
		if (hit(paddr, SLR_IDX_STAT)) begin
			rd_word = {3'h0, link_ctl};
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0;
		end else if (rd_acc) begin
			prdata <= {24'h0, rd_word};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sync inputs and source select
	slr_sync3 #(.RST_VAL(1'b1)) u_se_sync (
		.core_clk(core_clk),
		.nrst(nrst),
		.din(single_ended_sync_pin_n),
		.dout(se_sync_n)
	);

	slr_sync3 #(.RST_VAL(1'b1)) u_diff_sync (
		.core_clk(core_clk),
		.nrst(nrst),
		.din(timestamp_diff_input_n),
		.dout(diff_sync_n)
	);

	slr_sync3 #(.RST_VAL(1'b0)) u_sysref_sync (
		.core_clk(core_clk),
		.nrst(nrst),
		.din(sysref),
		.dout(sysref_s)
	);

	always_comb begin
		sync_req_d = !syncn_q[SLR_SYNCN_BIT];
		unique case (ctrl_q[SLR_SEL_HI:SLR_SEL_LO])
			SLR_SEL_SE_PIN: sync_req_d = sync_req_d || !se_sync_n;
			SLR_SEL_DIFF: sync_req_d = sync_req_d || !diff_sync_n;
			default: sync_req_d = sync_req_d;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Multiframe counter; cleared to zero while link off, sysref ignored then
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sysref_prev_q <= 1'b0;
		end else begin
			sysref_prev_q <= sysref_s;
		end
	end

	assign sysref_rise = sysref_s && !sysref_prev_q && link_on;

	slr_lmfc #(.K_W(K_W)) u_lmfc (
		.core_clk(core_clk),
		.nrst(nrst),
		.run(link_on),
		.align(sysref_rise),
		.km1(link_cfg.frames_per_multiframe_minus_one),
		.count(cnt_w),
		.boundary(bnd_w)
	);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lmfc_count <= '0;
		end else begin
			lmfc_count <= cnt_w;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lmfc_boundary <= 1'b0;
		end else begin
			lmfc_boundary <= bnd_w;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Applied config: frozen while running, loaded while link off
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			mode_cfg_q <= SLR_RST_MODE[SLR_FLD5_HI:0];
		end else if (!link_on) begin
			mode_cfg_q <= mode_q[SLR_FLD5_HI:0];
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			km1_cfg_q <= SLR_RST_KM1[SLR_FLD5_HI:0];
		end else if (!link_on) begin
			km1_cfg_q <= km1_q[SLR_FLD5_HI:0];
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			fmt_cfg_q <= SLR_RST_CTRL[SLR_FMT_BIT];
		end else if (!link_on) begin
			fmt_cfg_q <= ctrl_q[SLR_FMT_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			scr_cfg_q <= SLR_RST_CTRL[SLR_SCR_BIT];
		end else if (!link_on) begin
			scr_cfg_q <= ctrl_q[SLR_SCR_BIT];
		end
	end

	assign link_cfg = {mode_cfg_q, km1_cfg_q, fmt_cfg_q,
		scr_cfg_q};

	////////////////////////////////////////////////////////////////////////
	// Link control outputs
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			link_rst_n_q <= 1'b0;
		end else begin
			link_rst_n_q <= link_on;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			serializer_pd_q <= 1'b1;
		end else begin
			serializer_pd_q <= !link_on;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			link_clk_en_q <= 1'b0;
		end else begin
			link_clk_en_q <= link_on;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lmfc_rst_n_q <= 1'b0;
		end else begin
			lmfc_rst_n_q <= link_on;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sync_request_q <= 1'b0;
		end else begin
			sync_request_q <= sync_req_d;
		end
	end

	assign link_ctl = {link_rst_n_q, serializer_pd_q, link_clk_en_q,
		lmfc_rst_n_q, sync_request_q};

endmodule : slr_regs

/* File: verification/slr_regs_sva.sv */
// Checker for the serial link register bank
`timescale 1ns/1ps
module slr_regs_sva
	import slr_pkg::*;
#(parameter int K_W = 5) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [SLR_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic single_ended_sync_pin_n,
	input wire logic timestamp_diff_input_n,
	input wire logic sysref,
	input wire logic calibration_enable,
	input wire slr_cfg_s link_cfg,
	input wire slr_ctl_s link_ctl,
	input wire logic [K_W-1:0] lmfc_count,
	input wire logic lmfc_boundary
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic [11:0] idx;
	logic hit;
	assign idx = paddr[13:2];
	assign hit = paddr[1:0] == 2'h0 &&
		(idx inside {[12'h200:12'h204], 12'h20f});
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence sw_req_s;
		psel && penable && pwrite && pstrb[0] && idx == SLR_IDX_SYNC &&
			paddr[1:0] == 2'h0 && !pwdata[0];
	endsequence
	wait_free_a: assert property (setup_s |=> pready)
		else $error("no ready in access");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	slave_err_a: assert property (setup_s |=> pslverr == !$past(hit))
		else $error("wrong slave error");
	link_pd_a: assert property (
		link_ctl.serializer_pd == !link_ctl.link_rst_n)
		else $error("power down not tied to link reset");
	clk_gate_a: assert property (link_ctl.link_clk_en ==
		link_ctl.link_rst_n && link_ctl.lmfc_rst_n == link_ctl.link_rst_n)
		else $error("clock gate mismatch");
	lmfc_hold_a: assert property (!link_ctl.lmfc_rst_n [*2] |->
		lmfc_count == '0 && !lmfc_boundary)
		else $error("counter moved in reset");
	k_wrap_a: assert property (link_ctl.lmfc_rst_n &&
		lmfc_count == link_cfg.frames_per_multiframe_minus_one
		|=> lmfc_count == '0)
		else $error("counter did not wrap");
	cfg_frozen_a: assert property (link_ctl.link_rst_n [*3] |->
		$stable(link_cfg))
		else $error("config changed while enabled");
	soft_sync_a: assert property (sw_req_s |->
		##[1:3] link_ctl.sync_request)
		else $error("soft sync ignored");
endmodule : slr_regs_sva
bind slr_regs slr_regs_sva #(.K_W(K_W)) chk_u (.core_clk(core_clk),
	.nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pstrb(pstrb),
	.pready(pready), .pslverr(pslverr),
	.single_ended_sync_pin_n(single_ended_sync_pin_n),
	.timestamp_diff_input_n(timestamp_diff_input_n), .sysref(sysref),
	.calibration_enable(calibration_enable), .link_cfg(link_cfg),
	.link_ctl(link_ctl), .lmfc_count(lmfc_count),
	.lmfc_boundary(lmfc_boundary));

/* File: verification/testbench.sv */
// Self-checking bench for the serial link register bank
`timescale 1ns/1ps
module testbench import slr_pkg::*;;
	logic core_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
	logic [SLR_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic [3:0] pstrb = '0;
	logic pready, pslverr, se_n = 1, ts_n = 1, sysref = 0, cal = 1;
	slr_cfg_s link_cfg;
	slr_ctl_s link_ctl;
	logic [4:0] lmfc_count;
	logic lmfc_boundary;
	int miscompares = 0, n_checks = 0, nb, j;
	logic [5:0] c;
	logic [5:0] tbl [8] = '{6'b000111, 6'b001010, 6'b011011, 6'b010110,
		6'b100010, 6'b101101, 6'b001101, 6'b110010};
	always #5 core_clk = ~core_clk;
	slr_regs dut_u (.core_clk(core_clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .single_ended_sync_pin_n(se_n),
		.timestamp_diff_input_n(ts_n), .sysref(sysref),
		.calibration_enable(cal), .link_cfg(link_cfg),
		.link_ctl(link_ctl), .lmfc_count(lmfc_count),
		.lmfc_boundary(lmfc_boundary));
	////////////////////////////////////////////////////////////////////
	task test_done;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] idx, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r, output logic e);
		int i;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= d;
		pstrb <= s;
		@(posedge core_clk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			miscompares++;
			test_done;
		end
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge core_clk);
	endtask : apb
	task wr(input logic [11:0] idx, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		logic e;
		apb(1'b1, idx, d, s, r, e);
	endtask : wr
	task rd(input logic [11:0] idx, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, idx, 32'h0, 4'h0, r, e);
		chk(r, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask : rd
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge core_clk);
		nrst <= 1;
		@(posedge core_clk);
		rd(SLR_IDX_LINK_EN, 32'h01, 0);
		rd(SLR_IDX_MODE, 32'h02, 0);
		rd(SLR_IDX_KM1, 32'h1f, 0);
		rd(SLR_IDX_SYNC, 32'h01, 0);
		rd(SLR_IDX_CTRL, 32'h02, 0);
		rd(SLR_IDX_STAT, 32'h16, 0);
		rd(12'h205, 32'h0, 1);
		wr(SLR_IDX_LINK_EN, 32'hfe, 4'h1);
		cal <= 0;
		rd(SLR_IDX_LINK_EN, 32'hfe, 0);
		rd(SLR_IDX_STAT, 32'h08, 0);
		sysref <= 1;
		nb = 0;
		for (j = 0; j < 16; j++) begin
			@(posedge core_clk);
			if (j == 8) sysref <= 0;
			if (lmfc_boundary !== 1'b0) nb++;
		end
		chk(32'(nb), 32'h0);
		chk(32'(lmfc_count), 32'h0);
		wr(SLR_IDX_MODE, 32'he5, 4'h1);
		wr(SLR_IDX_KM1, 32'he3, 4'h1);
		wr(SLR_IDX_KM1, 32'h07, 4'h0);
		wr(SLR_IDX_CTRL, 32'hf9, 4'h1);
		rd(SLR_IDX_MODE, 32'he5, 0);
		rd(SLR_IDX_KM1, 32'he3, 0);
		rd(SLR_IDX_CTRL, 32'hf9, 0);
		chk(32'(link_cfg), 32'({5'h05, 5'h03, 2'h1}));
		cal <= 1;
		wr(SLR_IDX_LINK_EN, 32'h01, 4'h1);
		chk(32'(link_cfg), 32'({5'h05, 5'h03, 2'h1}));
		nb = 0;
		while (lmfc_boundary !== 1'b1 && nb < 64) begin
			@(posedge core_clk);
			nb++;
		end
		j = 1;
		@(posedge core_clk);
		while (lmfc_boundary !== 1'b1 && j < 64) begin
			@(posedge core_clk);
			j++;
		end
		chk(32'(j), 32'h4);
		for (j = 0; j < 8; j++) begin
			c = tbl[j];
			wr(SLR_IDX_LINK_EN, 32'h00, 4'h1);
			wr(SLR_IDX_CTRL, {28'h0, c[5:4], 2'h2}, 4'h1);
			wr(SLR_IDX_SYNC, {31'h0, c[1]}, 4'h1);
			wr(SLR_IDX_LINK_EN, 32'h01, 4'h1);
			se_n <= c[3];
			ts_n <= c[2];
			repeat (8) @(posedge core_clk);
			chk(32'(link_ctl.sync_request), 32'(c[0]));
			se_n <= 1;
			ts_n <= 1;
		end
		wr(SLR_IDX_LINK_EN, 32'h00, 4'h1);
		cal <= 0;
		test_done;
	end
endmodule : testbench
